// [verilog/fcp_pkg.sv]
// Constants shared by the flash command logic
package fcp_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 50;
  localparam int unsigned STATUS_WRITE_TIME_US = 5000;
  localparam int unsigned PROGRAM_TIME_US    = 1000;
  localparam int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_CYCLES     = PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PAGE_BYTES         = 256;

  localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_VOLATILE_WE   = 8'h50;
  localparam logic [7:0] OPC_SR_WRITE1     = 8'h01;
  localparam logic [7:0] OPC_SR_WRITE2     = 8'h31;
  localparam logic [7:0] OPC_SR_WRITE3     = 8'h11;
  localparam logic [7:0] OPC_RDSR1         = 8'h05;
  localparam logic [7:0] OPC_RDSR2         = 8'h35;
  localparam logic [7:0] OPC_RDSR3         = 8'h15;
  localparam logic [7:0] OPC_READ_EXT      = 8'hC8;
  localparam logic [7:0] OPC_WRITE_EXT     = 8'hC5;
  localparam logic [7:0] OPC_ENTER_32BIT   = 8'hB7;
  localparam logic [7:0] OPC_EXIT_32BIT    = 8'hE9;
  localparam logic [7:0] OPC_PAGE_PROGRAM  = 8'h02;

  // Status bits packed as {sr3, sr2, sr1}
  localparam int unsigned BIT_BUSY      = 0;
  localparam int unsigned BIT_WE_LATCH  = 1;
  localparam int unsigned BIT_BP_LO     = 2;
  localparam int unsigned BIT_TOP_BOT   = 6;
  localparam int unsigned BIT_ADDR_MODE = 16;
  localparam int unsigned BIT_ADDR_BOOT = 17;
  localparam logic [23:0] SR_WRITE_MASK = 24'hE2_3BFC;
  localparam logic [23:0] SR_OTP_MASK   = 24'h00_3800;
  localparam logic [23:0] SR_VOL_KEEP   = 24'h00_3900;
  localparam logic [23:0] SR_RESET      = 24'h00_0000;
  localparam logic [7:0]  EXT_RESET     = 8'h00;
  localparam logic [9:0]  BLOCK_COUNT   = 10'h200;
endpackage : fcp_pkg

// [verilog/fcp_page_buf.sv]
// Page buffer holding program data, registered read port
module fcp_page_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // fcp_page_buf

// [verilog/fcp_flash_cmd.sv]
// Serial flash command logic: status writes, extended address, address mode, page program
// Notes on behaviour
// - Status write changes only writable bits; read-only positions keep their value.
// - Lock bits once set to one stay one until rst_b clears the status registers.
// - Non-volatile status write needs write enable latch set, else rejected.
// - Volatile enable makes next status write touch volatile copy; latch stays zero.
// - Volatile write leaves second status-protect bit and lock bits unchanged.
// - Power-up reset loads SR_RESET into both copies; a reset request reloads the stored non-volatile ones.
// - Status write executes only if select rises after 8, 16 or 24 bits.
// - Non-volatile status write runs timed busy cycle, then clears busy and latch.
// - Volatile status write applies at select rise with busy staying zero.
// - First status write opcode with one byte updates register one only.
// - Extension register read shifts out on falling clock, MSB first.
// - 24-bit mode uses extension register as top address byte; 32-bit ignores it.
// - Extension register write needs latch set and one data byte.
// - Extension register clears at power-up and every reset.
// - In 32-bit mode an address top byte overwrites the extension register.
// - Enter and exit opcodes switch address width when select rises.
// - Page program: latch set, opcode, address, one to 256 data bytes.
// - Program data address wraps within the page, later bytes overwrite.
// - Program runs only on byte-aligned select rise; busy cycle then clears latch.
// - Program into a protected region is skipped.
// - Write enable opcode sets the write enable latch.
module fcp_flash_cmd #(
  parameter int unsigned STATUS_WRITE_CYCLES = fcp_pkg::STATUS_WRITE_CYCLES,
  parameter int unsigned PROGRAM_CYCLES      = fcp_pkg::PROGRAM_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        cs_b,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe,
  input  wire logic        four_line_command_mode,
  input  wire logic        soft_reset,
  output logic             busy,
  output logic             write_enable_latch,
  output logic             address_mode_flag,
  output logic [7:0]       ext_addr,
  output logic [23:0]      status_regs,
  output logic             prog_start,
  output logic [31:0]      prog_addr,
  output logic [8:0]       prog_len,
  input  wire logic [7:0]  pg_rd_addr,
  output logic [7:0]       pg_rd_data
);
  typedef enum logic [2:0] {
    FCP_OPC, FCP_ADDR, FCP_DATA, FCP_READ, FCP_IGNORE
  } fcp_state_t;
  typedef enum logic [1:0] {
    FCP_JOB_NONE, FCP_JOB_SR, FCP_JOB_PROG
  } fcp_job_t;

  typedef struct packed {
    logic [1:0]  sclk_sy;
    logic [1:0]  cs_sy;
    logic [3:0]  io_m;
    logic [3:0]  io_s;
    logic        sclk_p;
    logic        cs_p;
    fcp_state_t  st;
    logic [7:0]  opc;
    logic [7:0]  sh;
    logic [2:0]  nbit;
    logic [2:0]  nbyte;
    logic [23:0] dat;
    logic [31:0] addr;
    logic [7:0]  out;
    logic [2:0]  obit;
    logic [3:0]  dout;
    logic        doe;
    logic [23:0] sr;
    logic [23:0] nv;
    logic [23:0] pend;
    logic        we_latch;
    logic        vol_en;
    logic        addr32;
    logic [7:0]  ext;
    fcp_job_t    job;
    logic [23:0] cnt;
    logic [8:0]  ppn;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        go;
    logic [31:0] paddr;
    logic [8:0]  plen;
  } fcp_regs_t;

  fcp_regs_t q;
  fcp_regs_t d;

  // Region check on 64 KB blocks; one block is protected at level one, doubling per level up to all blocks from level ten
  function automatic logic fcp_protected(input logic bottom, input logic [3:0] bp,
                                         input logic [31:0] a);
    logic [9:0] n;
    logic [9:0] blk;
    n   = 10'h000;
    blk = {1'b0, a[24:16]};
    if (bp >= 4'hA) begin
      n = fcp_pkg::BLOCK_COUNT;
    end else if (bp != 4'h0) begin
      n = 10'(10'h001 << (bp - 4'h1));
    end
    if (bottom) begin
      fcp_protected = blk < n;
    end else begin
      fcp_protected = blk >= 10'(fcp_pkg::BLOCK_COUNT - n);
    end
  endfunction

  // Status merge: write only writable positions, keep lock bits sticky
  function automatic logic [23:0] fcp_merge(input logic [23:0] old, input logic [23:0] din,
                                            input logic [23:0] be, input logic vol);
    logic [23:0] m;
    logic [23:0] r;
    m = fcp_pkg::SR_WRITE_MASK & be;
    r = (old & ~m) | (din & m);
    r = r | (old & fcp_pkg::SR_OTP_MASK);
    if (vol) begin
      r = (r & ~fcp_pkg::SR_VOL_KEEP) | (old & fcp_pkg::SR_VOL_KEEP);
    end
    fcp_merge = r;
  endfunction

  function automatic logic [23:0] fcp_view(input fcp_regs_t s);
    logic [23:0] v;
    v = s.sr;
    v[fcp_pkg::BIT_BUSY] = (s.job != FCP_JOB_NONE);
    v[fcp_pkg::BIT_WE_LATCH]  = s.we_latch;
    v[fcp_pkg::BIT_ADDR_MODE] = s.addr32;
    fcp_view = v;
  endfunction

  logic        rise;
  logic        fall;
  logic        cs_rise;
  logic        cs_low;
  logic        bdone;
  logic [7:0]  bval;
  logic [2:0]  step;
  logic [7:0]  rdval;
  logic [2:0]  ndat;
  logic [23:0] din;
  logic [23:0] be;
  logic        sr_ok;
  logic        idle;
  logic [23:0] sview;

  always_comb begin
    d       = q;
    cs_low  = ~q.cs_sy[1];
    rise    = q.sclk_sy[1] & ~q.sclk_p & cs_low;
    fall    = ~q.sclk_sy[1] & q.sclk_p & cs_low;
    cs_rise = q.cs_sy[1] & ~q.cs_p;
    step    = four_line_command_mode ? 3'd4 : 3'd1;
    bval    = four_line_command_mode ? {q.sh[3:0], q.io_s} : {q.sh[6:0], q.io_s[0]};
    bdone   = rise && (3'(q.nbit + step) == 3'd0);
    idle    = (q.job == FCP_JOB_NONE);
    ndat    = 3'(q.nbyte - 3'd1);
    rdval   = 8'h00;
    din     = 24'h00_0000;
    be      = 24'h00_0000;
    sr_ok   = 1'b0;
    sview   = fcp_view(q);

    d.sclk_sy = {q.sclk_sy[0], sclk};
    d.cs_sy   = {q.cs_sy[0], cs_b};
    d.io_m    = io_i;
    d.io_s    = q.io_m;
    d.sclk_p  = q.sclk_sy[1];
    d.cs_p    = q.cs_sy[1];
    d.wr_en   = 1'b0;
    d.go      = 1'b0;

    case (q.opc)
      fcp_pkg::OPC_RDSR2:    rdval = sview[15:8];
      fcp_pkg::OPC_RDSR3:    rdval = sview[23:16];
      fcp_pkg::OPC_READ_EXT: rdval = q.ext;
      default:               rdval = sview[7:0];
    endcase

    case (q.opc)
      fcp_pkg::OPC_SR_WRITE1: begin
        din   = q.dat;
        be    = (ndat == 3'd1) ? 24'h00_00FF :
                (ndat == 3'd2) ? 24'h00_FFFF : 24'hFF_FFFF;
        sr_ok = (ndat >= 3'd1) && (ndat <= 3'd3);
      end
      fcp_pkg::OPC_SR_WRITE2: begin
        din   = {8'h00, q.dat[7:0], 8'h00};
        be    = 24'h00_FF00;
        sr_ok = (ndat == 3'd1);
      end
      fcp_pkg::OPC_SR_WRITE3: begin
        din   = {q.dat[7:0], 16'h0000};
        be    = 24'hFF_0000;
        sr_ok = (ndat == 3'd1);
      end
      default: begin
        sr_ok = 1'b0;
      end
    endcase

    if (rise) begin
      d.sh   = bval;
      d.nbit = 3'(q.nbit + step);
    end

    if (bdone) begin
      if (q.nbyte != 3'd7) begin
        d.nbyte = 3'(q.nbyte + 3'd1);
      end
      case (q.st)
        FCP_OPC: begin
          d.opc = bval;
          d.st  = FCP_IGNORE;
          case (bval)
            fcp_pkg::OPC_RDSR1, fcp_pkg::OPC_RDSR2,
            fcp_pkg::OPC_RDSR3, fcp_pkg::OPC_READ_EXT: begin
              d.st   = FCP_READ;
              d.obit = 3'd0;
            end
            fcp_pkg::OPC_SR_WRITE1, fcp_pkg::OPC_SR_WRITE2, fcp_pkg::OPC_SR_WRITE3: begin
              if (idle && (q.we_latch || q.vol_en)) begin
                d.st = FCP_DATA;
              end
            end
            fcp_pkg::OPC_WRITE_EXT: begin
              if (idle && q.we_latch) begin
                d.st = FCP_DATA;
              end
            end
            fcp_pkg::OPC_PAGE_PROGRAM: begin
              if (idle && q.we_latch) begin
                d.st  = FCP_ADDR;
                d.ppn = 9'h000;
              end
            end
            default: begin
              // Later bytes of an unknown frame must never decode as a new opcode
              d.st = FCP_IGNORE;
            end
          endcase
        end
        FCP_ADDR: begin
          d.addr = {q.addr[23:0], bval};
          if (q.nbyte == (q.addr32 ? 3'd4 : 3'd3)) begin
            d.st = FCP_DATA;
            if (q.addr32) begin
              d.ext = q.addr[23:16];
            end else begin
              d.addr = {q.ext, q.addr[15:0], bval};
            end
          end
        end
        FCP_DATA: begin
          if (q.opc == fcp_pkg::OPC_PAGE_PROGRAM) begin
            d.wr_en   = 1'b1;
            d.wr_addr = 8'(q.addr[7:0] + q.ppn[7:0]);
            d.wr_data = bval;
            if (q.ppn != 9'(fcp_pkg::PAGE_BYTES)) begin
              d.ppn = 9'(q.ppn + 9'h001);
            end
          end else if (q.nbyte <= 3'd3) begin
            d.dat[8*ndat +: 8] = bval;
          end
        end
        default: begin
          d.st = q.st;
        end
      endcase
    end

    // Read data leaves on falling edges, repeating while select stays low
    if (fall && q.st == FCP_READ) begin
      d.doe = 1'b1;
      if (four_line_command_mode) begin
        d.dout = (q.obit == 3'd0) ? rdval[7:4] : q.out[7:4];
        d.out  = (q.obit == 3'd0) ? {rdval[3:0], 4'h0} : {q.out[3:0], 4'h0};
      end else begin
        d.dout = {2'b00, (q.obit == 3'd0) ? rdval[7] : q.out[7], 1'b0};
        d.out  = (q.obit == 3'd0) ? {rdval[6:0], 1'b0} : {q.out[6:0], 1'b0};
      end
      d.obit = 3'(q.obit + step);
    end

    if (!cs_low) begin
      d.doe = 1'b0;
    end

    if (cs_rise) begin
      d.st    = FCP_OPC;
      d.nbit  = 3'd0;
      d.nbyte = 3'd0;
      d.obit  = 3'd0;
      if (q.nbit == 3'd0) begin
        if (q.nbyte == 3'd1 && idle) begin
          case (q.opc)
            fcp_pkg::OPC_WRITE_ENABLE:  d.we_latch = 1'b1;
            fcp_pkg::OPC_WRITE_DISABLE: d.we_latch = 1'b0;
            fcp_pkg::OPC_VOLATILE_WE:   d.vol_en = 1'b1;
            fcp_pkg::OPC_ENTER_32BIT:   d.addr32 = 1'b1;
            fcp_pkg::OPC_EXIT_32BIT:    d.addr32 = 1'b0;
            default:                    d.we_latch = q.we_latch;
          endcase
        end
        if (q.st == FCP_DATA && sr_ok) begin
          if (q.we_latch) begin
            d.pend = fcp_merge(q.nv, din, be, 1'b0);
            d.job  = FCP_JOB_SR;
            d.cnt  = 24'(STATUS_WRITE_CYCLES);
          end else begin
            d.sr = fcp_merge(q.sr, din, be, 1'b1);
          end
        end
        if (q.st == FCP_DATA && q.opc == fcp_pkg::OPC_WRITE_EXT && ndat == 3'd1) begin
          d.ext = q.dat[7:0];
          d.we_latch = 1'b0;
        end
        if (q.st == FCP_DATA && q.opc == fcp_pkg::OPC_PAGE_PROGRAM && q.ppn != 9'h000
            && !fcp_protected(q.sr[fcp_pkg::BIT_TOP_BOT], q.sr[fcp_pkg::BIT_BP_LO +: 4],
                              q.addr)) begin
          d.job   = FCP_JOB_PROG;
          d.cnt   = 24'(PROGRAM_CYCLES);
          d.go    = 1'b1;
          d.paddr = q.addr;
          d.plen  = q.ppn;
        end
      end
      if (q.nbyte != 3'd0 && q.opc != fcp_pkg::OPC_VOLATILE_WE) begin
        d.vol_en = 1'b0;
      end
    end

    if (!idle) begin
      d.cnt = 24'(q.cnt - 24'h00_0001);
      if (q.cnt == 24'h00_0001) begin
        d.job = FCP_JOB_NONE;
        d.we_latch = 1'b0;
        if (q.job == FCP_JOB_SR) begin
          d.nv = q.pend;
          d.sr = q.pend;
        end
      end
    end

    // Reset request reloads volatile state from the stored copy
    if (q.io_s[3] == 1'b0 && soft_reset) begin
      d.ext    = fcp_pkg::EXT_RESET;
      d.sr     = q.nv;
      d.addr32 = q.nv[fcp_pkg::BIT_ADDR_BOOT];
      d.vol_en = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.sclk_sy <= 2'b00;
      q.cs_sy   <= 2'b11;
      q.sclk_p  <= 1'b0;
      q.cs_p    <= 1'b1;
      q.st      <= FCP_OPC;
      q.job     <= FCP_JOB_NONE;
      q.sr      <= fcp_pkg::SR_RESET;
      q.nv      <= fcp_pkg::SR_RESET;
      q.ext     <= fcp_pkg::EXT_RESET;
    end else begin
      q <= d;
    end
  end

  fcp_page_buf #(
    .WIDTH (8),
    .DEPTH (fcp_pkg::PAGE_BYTES)
  ) u_page_buf (
    .clk     (clk),
    .wr_en   (q.wr_en),
    .wr_addr (q.wr_addr),
    .wr_data (q.wr_data),
    .rd_addr (pg_rd_addr),
    .rd_data (pg_rd_data)
  );

  assign io_o               = q.dout;
  assign io_oe              = q.doe ? (four_line_command_mode ? 4'hF : 4'h2) : 4'h0;
  assign busy               = (q.job != FCP_JOB_NONE);
  assign write_enable_latch = q.we_latch;
  assign address_mode_flag  = q.addr32;
  assign ext_addr           = q.ext;
  assign status_regs        = fcp_view(q);
  assign prog_start         = q.go;
  assign prog_addr          = q.paddr;
  assign prog_len           = q.plen;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_sr_cmd_ok;
    cs_rise && q.nbit == 3'd0 && q.st == FCP_DATA && sr_ok;
  endsequence
  sequence s_busy_done;
    busy ##1 !busy;
  endsequence

  a_nv_write_busy: assert property ((s_sr_cmd_ok and q.we_latch) |=>
    busy && q.job == FCP_JOB_SR)
    else $error("non-volatile status write did not start busy");
  a_busy_clears_latch: assert property (s_busy_done |-> !write_enable_latch)
    else $error("latch not cleared after busy cycle");
  a_vol_no_busy: assert property ((s_sr_cmd_ok and (!q.we_latch && idle)) |=> !busy)
    else $error("volatile status write raised busy");
  a_otp_sticky: assert property ((q.sr & fcp_pkg::SR_OTP_MASK) != 24'h00_0000 |=>
    ((q.sr & $past(q.sr) & fcp_pkg::SR_OTP_MASK) == ($past(q.sr) & fcp_pkg::SR_OTP_MASK)))
    else $error("lock bit cleared");
  a_ro_bits_kept: assert property (!$past(soft_reset) && !$past(busy) |->
    ((q.sr & ~fcp_pkg::SR_WRITE_MASK) == ($past(q.sr) & ~fcp_pkg::SR_WRITE_MASK)))
    else $error("read-only status bit changed");
  a_wel_set: assert property (cs_rise && q.nbit == 3'd0 && q.nbyte == 3'd1 && idle &&
    q.opc == fcp_pkg::OPC_WRITE_ENABLE |=> write_enable_latch)
    else $error("write enable not latched");
  a_enter_32bit: assert property (cs_rise && q.nbit == 3'd0 && q.nbyte == 3'd1 && idle &&
    q.opc == fcp_pkg::OPC_ENTER_32BIT |=> address_mode_flag)
    else $error("address mode not entered");
  a_prog_needs_latch: assert property (prog_start |->
    $past(q.we_latch) && prog_len != 9'h000)
    else $error("program started without latch or data");
  a_prog_len_cap: assert property (prog_start |-> prog_len <= 9'h100)
    else $error("program length above page size");
  a_ext_write: assert property (cs_rise && q.nbit == 3'd0 && q.st == FCP_DATA &&
    q.opc == fcp_pkg::OPC_WRITE_EXT && ndat == 3'd1 |=> ext_addr == $past(q.dat[7:0]))
    else $error("extension register not written");
endmodule // fcp_flash_cmd

// [sim/fcp_host_model.sv]
// Host serial controller model: drives select, serial clock and data lines
module fcp_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] io_o,
  input  wire logic       quad,
  input  wire logic       hold_low,
  output logic            sclk,
  output logic            cs_b,
  output logic [3:0]      io_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    io_i = 4'h9;
  end

  // Released lines: pins 1 and 2 go high, pin 3 goes to ~hold_low, the data line flips so stale bits never match
  task automatic release_lines();
    io_i = {~hold_low, 2'b11, ~io_i[0]};
  endtask

  // Eight clk per serial clock, data held four clk on both sides of the rise
  task automatic edge_pair(input logic [3:0] v);
    sclk = 1'b0;
    io_i = v;
    repeat (4) @(negedge clk);
    sclk = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // One frame: nb bytes from the top of d, xb stray bits, then nr bytes read back
  task automatic xfer(input logic [63:0] d, input int nb, input int xb,
                      input int nr, output logic [7:0] r);
    logic [7:0] b;
    r = 8'h00;
    @(negedge clk);
    cs_b = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < nb; i++) begin
      b = d[63-8*i -: 8];
      if (quad) begin
        edge_pair(b[7:4]);
        edge_pair(b[3:0]);
      end else begin
        for (int k = 7; k >= 0; k--) edge_pair({3'b111, b[k]});
      end
    end
    for (int k = 0; k < xb; k++) edge_pair(4'hE);
    for (int k = 0; k < 8 * nr; k++) begin
      edge_pair({3'b111, ~io_i[0]});
      r = {r[6:0], io_o[1]};
    end
    sclk = 1'b0;
    repeat (4) @(negedge clk);
    cs_b = 1'b1;
    release_lines();
    repeat (12) @(negedge clk);
  endtask
endmodule // fcp_host_model

// [sim/testbench.sv]
// Self-checking bench for the flash command logic
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SW_CYC = 300;
  localparam int unsigned PG_CYC = 200;
  logic        clk, rst_b, sclk, cs_b, four_line_command_mode, soft_reset, hold_low;
  logic        busy, write_enable_latch, address_mode_flag, prog_start;
  logic [3:0]  io_i, io_o, io_oe;
  logic [7:0]  ext_addr, pg_rd_addr, pg_rd_data, rd;
  logic [8:0]  prog_len;
  logic [23:0] status_regs;
  logic [31:0] prog_addr;
  int          n_errors = 0, check_count = 0, cycles = 0;
  int          busy_run = 0, last_run = 0, n_busy = 0, n_prog = 0, nb, np;

  fcp_flash_cmd #(.STATUS_WRITE_CYCLES(SW_CYC), .PROGRAM_CYCLES(PG_CYC)) dut (
    .clk, .rst_b, .sclk, .cs_b, .io_i, .io_o, .io_oe, .four_line_command_mode,
    .soft_reset, .busy, .write_enable_latch, .address_mode_flag, .ext_addr,
    .status_regs, .prog_start, .prog_addr, .prog_len, .pg_rd_addr, .pg_rd_data);

  fcp_host_model host (.clk, .io_o, .quad(four_line_command_mode), .hold_low,
    .sclk, .cs_b, .io_i);

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Busy length and program starts are counted here so checks need no fixed waits
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (prog_start === 1'b1) n_prog <= n_prog + 1;
    if (busy === 1'b1) busy_run <= busy_run + 1;
    else if (busy_run != 0) begin
      last_run <= busy_run;
      busy_run <= 0;
      n_busy <= n_busy + 1;
    end
    if (cycles == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [63:0] d, input int n, input int xb = 0);
    host.xfer(d, n, xb, 0, rd);
  endtask

  task automatic op(input logic [7:0] o);
    cmd({o, 56'h0}, 1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk_flag(busy, 1'b0);
    repeat (2) @(negedge clk);
  endtask

  task automatic pb(input logic [7:0] a, input logic [7:0] e);
    pg_rd_addr = a;
    repeat (2) @(negedge clk);
    chk_val(32'(pg_rd_data), 32'(e));
  endtask

  task automatic t_reset();
    chk_val(32'(status_regs), 32'h0000_0000);
    chk_val(32'(ext_addr), 32'h0000_0000);
    chk_flag(address_mode_flag, 1'b0);
    chk_val(32'(io_oe), 32'h0000_0000);
  endtask

  task automatic t_refused();
    cmd(64'h017C_0000_0000_0000, 2);
    chk_val(32'(status_regs), 32'h0000_0000);
    op(8'h06);
    chk_flag(write_enable_latch, 1'b1);
    cmd(64'h017C_0000_0000_0000, 2, 3);
    chk_val(32'(status_regs), 32'h0000_0002);
    op(8'h04);
    chk_flag(write_enable_latch, 1'b0);
  endtask

  task automatic t_nv_write();
    op(8'h06);
    cmd(64'h017C_0000_0000_0000, 2);
    host.xfer({8'h05, 56'h0}, 1, 0, 1, rd);
    chk_val(32'(rd), 32'h0000_0003);
    wait_idle();
    chk_val(32'(last_run), 32'(SW_CYC));
    chk_flag(write_enable_latch, 1'b0);
    chk_val(32'(status_regs), 32'h0000_007C);
    op(8'h06);
    cmd(64'h0103_3A61_0000_0000, 4);
    wait_idle();
    chk_val(32'(status_regs), 32'h0060_3A00);
    op(8'h06);
    cmd(64'h0100_0000_0000_0000, 4);
    wait_idle();
    chk_val(32'(status_regs), 32'h0000_3800);
  endtask

  task automatic t_volatile();
    nb = n_busy;
    op(8'h50);
    chk_flag(write_enable_latch, 1'b0);
    cmd(64'h010C_0100_0000_0000, 3);
    chk_val(32'(status_regs), 32'h0000_380C);
    chk_val(32'(n_busy), 32'(nb));
  endtask

  task automatic t_ext();
    op(8'h06);
    cmd(64'hC5A5_0000_0000_0000, 2);
    chk_val(32'(ext_addr), 32'h0000_00A5);
    cmd(64'hC577_0000_0000_0000, 2);
    chk_val(32'(ext_addr), 32'h0000_00A5);
    host.xfer({8'hC8, 56'h0}, 1, 0, 1, rd);
    chk_val(32'(rd), 32'h0000_00A5);
  endtask

  task automatic t_program();
    op(8'hB7);
    chk_flag(address_mode_flag, 1'b1);
    np = n_prog;
    op(8'h06);
    cmd(64'h0237_0120_FE11_2233, 8);
    chk_val(32'(n_prog), 32'(np + 1));
    chk_val(prog_addr, 32'h3701_20FE);
    chk_val(32'(ext_addr), 32'h0000_0037);
    chk_val(32'(prog_len), 32'h0000_0003);
    wait_idle();
    chk_val(32'(last_run), 32'(PG_CYC));
    chk_flag(write_enable_latch, 1'b0);
    pb(8'hFE, 8'h11);
    pb(8'hFF, 8'h22);
    pb(8'h00, 8'h33);
    op(8'hE9);
    chk_flag(address_mode_flag, 1'b0);
    host.xfer({8'hC8, 56'h0}, 1, 0, 1, rd);
    chk_val(32'(rd), 32'h0000_0037);
    op(8'h06);
    cmd(64'h0200_1000_AB00_0000, 5, 1);
    chk_val(32'(n_prog), 32'(np + 1));
    op(8'h06);
    cmd(64'h0200_1000_AB00_0000, 5);
    chk_val(prog_addr, 32'h3700_1000);
    wait_idle();
    op(8'h06);
    cmd(64'hC501_0000_0000_0000, 2);
    op(8'h06);
    cmd(64'h02FF_0000_CD00_0000, 5);
    chk_val(32'(n_prog), 32'(np + 2));
    chk_flag(write_enable_latch, 1'b1);
  endtask

  task automatic t_soft_reset();
    hold_low = 1'b1;
    host.release_lines();
    repeat (4) @(negedge clk);
    soft_reset = 1'b1;
    repeat (4) @(negedge clk);
    soft_reset = 1'b0;
    hold_low = 1'b0;
    host.release_lines();
    repeat (4) @(negedge clk);
    chk_val(32'(ext_addr), 32'h0000_0000);
    // Reset reloads the stored copy; the latch left set by the skipped program survives
    chk_val(32'(status_regs), 32'h0000_3802);
  endtask

  task automatic t_four_line();
    four_line_command_mode = 1'b1;
    op(8'h04);
    chk_flag(write_enable_latch, 1'b0);
    op(8'h06);
    chk_flag(write_enable_latch, 1'b1);
    // Status byte 02 leaves as nibbles 0 then 2, so line one alternates 0 and 1
    host.xfer({8'h05, 56'h0}, 1, 0, 1, rd);
    chk_val(32'(rd), 32'h0000_0055);
    four_line_command_mode = 1'b0;
  endtask

  initial begin
    rst_b = 1'b0;
    soft_reset = 1'b0;
    hold_low = 1'b0;
    four_line_command_mode = 1'b0;
    pg_rd_addr = 8'h00;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_refused();
    t_nv_write();
    t_volatile();
    t_ext();
    t_program();
    t_soft_reset();
    t_four_line();
    finish_test();
  end
endmodule // testbench
